// file: tws_eeprom_dev.sv
// EEPROM end of the two-wire link: framing, addressing, page buffer and programming.
// Assumes an external byte array on the mem_* port with combinational read data.
//
// Overview of operation
// - SDA changes with SCL high mean start/stop
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - Acknowledge each 8-bit word on ninth clock
// - Standby at power-up, after stop and programming
// - Controller recovers with up to nine clocks
// - Address word: one, then strap-matched select bits; the code matches the middle select bit against the inverted strap
// - Three block bits are location top bits
// - Last address bit one reads, zero writes
// - Match acknowledges; mismatch stays silent, goes standby
// - Byte write: location byte, data byte, both acknowledged
// - Stop after write starts timed programming
// - No acknowledge while programming runs
// - Page write takes up to sixteen bytes
// - Controller closes page write with stop
// - Only low four location bits increment
// - Extra page bytes overwrite earlier ones
// - Polling acknowledged only after programming ends
// - Location counter holds last location plus one
// - Read counter wraps across whole array
// - Controller acknowledge continues read; no acknowledge ends
// - Random read: dummy write, repeated start
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_eeprom_dev #(
    parameter int PROG_CYCLES = `TWS_PROG_CYC
) (
    // System
    input wire logic sys_clk,
    input wire logic rst_b,
    // Two-wire link
    tws_link_if.dev link,
    // Strap pins
    input wire logic [2:0] chip_select_straps,
    // Memory array port
    output logic [`TWS_ADDR_W-1:0] mem_addr_r,
    output logic [7:0] mem_wdata_r,
    output logic mem_we_r,
    input wire logic [7:0] mem_rdata,
    // Status
    output logic busy_r,
    output logic standby_r
);
    import tws_pkg::*;

    localparam int PC_W = $clog2(PROG_CYCLES + 1);
    localparam int PAGE = `TWS_PAGE_BYTES;

    if (PROG_CYCLES < PAGE + 2) begin : g_bad_prog
        $error("PROG_CYCLES too small to write out the page buffer");
    end

    tws_dev_st_t st_r;
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic [2:0] strap_s1_r;
    logic [2:0] strap_s2_r;
    logic [2:0] strap_s3_r;
    logic [2:0] strap_f_r;
    logic scl_f_r;
    logic sda_f_r;
    logic scl_p_r;
    logic sda_p_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic in_ack_r;
    logic drive_low_r;
    logic [`TWS_ADDR_W-1:0] loc_r;
    logic have_data_r;
    logic prog_go_r;
    logic [PC_W-1:0] prog_cnt_r;
    logic [4:0] prog_idx_r;
    logic [7:0] buf_r [PAGE];
    logic [PAGE-1:0] valid_r;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic byte_done;
    logic addr_match;
    logic wr_accept;

    // Open-drain output: only ever pull low
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = drive_low_r;

    // Three-flop input synchronisers with agreement filter
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[1:0], link.scl};
            sda_s_r <= {sda_s_r[1:0], link.sda};
            if (scl_s_r[1] == scl_s_r[2]) begin
                scl_f_r <= scl_s_r[2];
            end
            if (sda_s_r[1] == sda_s_r[2]) begin
                sda_f_r <= sda_s_r[2];
            end
            scl_p_r <= scl_f_r;
            sda_p_r <= sda_f_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
            strap_s3_r <= 3'h0;
            strap_f_r <= 3'h0;
        end else begin
            strap_s1_r <= chip_select_straps;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            if (strap_s2_r == strap_s3_r) begin
                strap_f_r <= strap_s3_r;
            end
        end
    end

    assign scl_rise = scl_f_r & ~scl_p_r;
    assign scl_fall = ~scl_f_r & scl_p_r;
    // Data edges while the clock stays high are framing events
    assign start_ev = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
    assign stop_ev = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;
    assign byte_done = scl_fall & ~in_ack_r & (bit_cnt_r == 4'h8);

    // Fixed one, straps with middle bit inverted, and no match while busy
    assign addr_match = shift_r[`TWS_DA_FIXED] & ~busy_r &
        (shift_r[`TWS_DA_SEL_MSB:`TWS_DA_SEL_LSB] ==
         {strap_f_r[2], ~strap_f_r[1], strap_f_r[0]});
    assign wr_accept = byte_done & (st_r == TWS_DS_DEV) & addr_match & ~shift_r[`TWS_DA_RW];

    // Link protocol engine
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= TWS_DS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            in_ack_r <= 1'b0;
            drive_low_r <= 1'b0;
            loc_r <= `TWS_LOC_RST;
            have_data_r <= 1'b0;
            prog_go_r <= 1'b0;
        end else begin
            prog_go_r <= 1'b0;
            if (start_ev) begin
                // Abort any byte, collected data is dropped
                st_r <= TWS_DS_DEV;
                bit_cnt_r <= 4'h0;
                in_ack_r <= 1'b0;
                drive_low_r <= 1'b0;
                have_data_r <= 1'b0;
            end else if (stop_ev) begin
                if (st_r == TWS_DS_WDAT && have_data_r) begin
                    prog_go_r <= 1'b1;
                end
                st_r <= TWS_DS_IDLE;
                drive_low_r <= 1'b0;
                have_data_r <= 1'b0;
            end else if (st_r == TWS_DS_IDLE) begin
                drive_low_r <= 1'b0;
            end else if (scl_rise) begin
                if (!in_ack_r) begin
                    if (st_r != TWS_DS_RDAT) begin
                        shift_r <= {shift_r[6:0], sda_f_r};
                    end
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end else if (st_r == TWS_DS_RDAT && sda_f_r) begin
                    // No acknowledge from the controller ends the read
                    st_r <= TWS_DS_IDLE;
                end
            end else if (scl_fall) begin
                if (in_ack_r) begin
                    in_ack_r <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    drive_low_r <= 1'b0;
                    if (st_r == TWS_DS_RDAT) begin
                        // Send byte at counter, advance over whole array
                        shift_r <= mem_rdata;
                        loc_r <= loc_r + 11'h001;
                        drive_low_r <= ~mem_rdata[7];
                    end
                end else if (bit_cnt_r == 4'h8) begin
                    in_ack_r <= 1'b1;
                    case (st_r)
                        TWS_DS_DEV: begin
                            if (addr_match) begin
                                drive_low_r <= 1'b1;
                                loc_r[10:8] <= shift_r[`TWS_DA_BLK_MSB:`TWS_DA_BLK_LSB];
                                st_r <= shift_r[`TWS_DA_RW] ? TWS_DS_RDAT : TWS_DS_WADR;
                            end else begin
                                st_r <= TWS_DS_IDLE;
                                in_ack_r <= 1'b0;
                            end
                        end
                        TWS_DS_WADR: begin
                            drive_low_r <= 1'b1;
                            loc_r[7:0] <= shift_r;
                            st_r <= TWS_DS_WDAT;
                        end
                        TWS_DS_WDAT: begin
                            drive_low_r <= 1'b1;
                            loc_r[3:0] <= loc_r[3:0] + 4'h1;
                            have_data_r <= 1'b1;
                        end
                        default: begin
                            drive_low_r <= 1'b0;
                        end
                    endcase
                end else if (st_r == TWS_DS_RDAT) begin
                    drive_low_r <= ~shift_r[3'h7 - bit_cnt_r[2:0]];
                end
            end
        end
    end

    // Page buffer, one entry per in-page location; later bytes replace earlier
    for (genvar i = 0; i < PAGE; i++) begin : g_page
        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                buf_r[i] <= 8'h00;
                valid_r[i] <= 1'b0;
            end else if (wr_accept) begin
                valid_r[i] <= 1'b0;
            end else if (byte_done && st_r == TWS_DS_WDAT && loc_r[3:0] == 4'(i)) begin
                buf_r[i] <= shift_r;
                valid_r[i] <= 1'b1;
            end
        end
    end

    // Self-timed programming: write out buffer, then hold busy for the full time
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
            prog_cnt_r <= '0;
            prog_idx_r <= 5'h00;
            mem_we_r <= 1'b0;
            mem_wdata_r <= 8'h00;
            mem_addr_r <= `TWS_LOC_RST;
        end else begin
            mem_we_r <= 1'b0;
            mem_addr_r <= loc_r;
            if (prog_go_r) begin
                busy_r <= 1'b1;
                prog_cnt_r <= '0;
                prog_idx_r <= 5'h00;
            end else if (busy_r) begin
                prog_cnt_r <= prog_cnt_r + 1'b1;
                if (!prog_idx_r[4]) begin
                    mem_we_r <= valid_r[prog_idx_r[3:0]];
                    mem_wdata_r <= buf_r[prog_idx_r[3:0]];
                    mem_addr_r <= {loc_r[10:4], prog_idx_r[3:0]};
                    prog_idx_r <= prog_idx_r + 5'h01;
                end
                if (prog_cnt_r == PC_W'(PROG_CYCLES - 1)) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            standby_r <= 1'b1;
        end else begin
            standby_r <= (st_r == TWS_DS_IDLE) & ~busy_r & ~prog_go_r;
        end
    end
endmodule

// file: tws_defs.svh
// Timing counts, address-word layout and sizes for the two-wire EEPROM link.
// Assumes a single system clock at the rate given below.
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

`define TWS_CLK_HZ 40000000
`define TWS_PROG_TIME_MS 10
`define TWS_PROG_CYC (`TWS_PROG_TIME_MS * (`TWS_CLK_HZ / 1000))
`define TWS_SCL_MAX_HZ 100000
`define TWS_SCL_QTR_CYC ((`TWS_CLK_HZ + 4 * `TWS_SCL_MAX_HZ - 1) / (4 * `TWS_SCL_MAX_HZ))
`define TWS_RECOVER_CLOCKS 9
`define TWS_BYTE_BITS 8
`define TWS_PAGE_BYTES 16
`define TWS_ADDR_W 11
`define TWS_DA_FIXED 7
`define TWS_DA_SEL_MSB 6
`define TWS_DA_SEL_LSB 4
`define TWS_DA_BLK_MSB 3
`define TWS_DA_BLK_LSB 1
`define TWS_DA_RW 0
`define TWS_LOC_RST 11'h000

`endif

// file: tws_pkg.sv
// Types shared by both ends of the two-wire EEPROM link.
// Assumes tws_defs.svh for all numeric constants.
package tws_pkg;
    typedef enum logic [2:0] {
        TWS_DS_IDLE,
        TWS_DS_DEV,
        TWS_DS_WADR,
        TWS_DS_WDAT,
        TWS_DS_RDAT
    } tws_dev_st_t;

    typedef enum logic [2:0] {
        TWS_CMD_START,
        TWS_CMD_STOP,
        TWS_CMD_WRITE,
        TWS_CMD_READ,
        TWS_CMD_RECOVER
    } tws_cmd_t;

    typedef enum logic [2:0] {
        TWS_CS_IDLE,
        TWS_CS_START,
        TWS_CS_STOP,
        TWS_CS_BIT,
        TWS_CS_RECOV
    } tws_ctl_st_t;
endpackage

// file: tws_link_if.sv
// Two-wire link between the bus controller and the EEPROM end.
// Assumes an external pull-up on the data line; level resolved from the enables.
`timescale 1ns/1ps
interface tws_link_if;
    logic scl;
    logic sda;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic host_sda_o;
    logic host_sda_oe;

    // Open-drain wire with pull-up: low while either end drives
    assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

    modport dev (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host (
        output scl,
        input sda,
        output host_sda_o,
        output host_sda_oe
    );
endinterface

// file: tws_bus_ctl.sv
// Bus controller end: turns single commands into start, stop, byte and recovery frames.
// Assumes one command at a time, issued only while ready_r is high.
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_bus_ctl #(
    parameter int QTR_CYC = `TWS_SCL_QTR_CYC
) (
    // System
    input wire logic sys_clk,
    input wire logic rst_b,
    // Two-wire link
    tws_link_if.host link,
    // Command port
    input wire logic cmd_valid,
    input wire tws_pkg::tws_cmd_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    // Results
    output logic ready_r,
    output logic done_r,
    output logic [7:0] rdata_r,
    output logic ack_seen_r
);
    import tws_pkg::*;

    localparam int QW = $clog2(QTR_CYC + 1);

    if (QTR_CYC < 8) begin : g_bad_qtr
        $error("QTR_CYC too small for the input synchroniser");
    end

    tws_ctl_st_t st_r;
    tws_cmd_t op_r;
    logic [QW-1:0] qcnt_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic nack_r;
    logic scl_r;
    logic sda_low_r;
    logic [2:0] sda_s_r;
    logic sda_f_r;
    logic tick;

    assign link.scl = scl_r;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_low_r;
    assign tick = (qcnt_r == QW'(QTR_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sda_s_r <= 3'h7;
            sda_f_r <= 1'b1;
        end else begin
            sda_s_r <= {sda_s_r[1:0], link.sda};
            if (sda_s_r[1] == sda_s_r[2]) begin
                sda_f_r <= sda_s_r[2];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || st_r == TWS_CS_IDLE || tick) begin
            qcnt_r <= '0;
        end else begin
            qcnt_r <= qcnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= TWS_CS_IDLE;
            op_r <= TWS_CMD_STOP;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            nack_r <= 1'b0;
            scl_r <= 1'b1;
            sda_low_r <= 1'b0;
            ready_r <= 1'b1;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            ack_seen_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (st_r == TWS_CS_IDLE) begin
                if (cmd_valid) begin
                    op_r <= cmd_op;
                    sh_r <= (cmd_op == TWS_CMD_READ) ? 8'hff : cmd_data;
                    nack_r <= cmd_nack;
                    q_r <= 2'h0;
                    bit_r <= 4'h0;
                    ready_r <= 1'b0;
                    case (cmd_op)
                        TWS_CMD_START: st_r <= TWS_CS_START;
                        TWS_CMD_STOP: st_r <= TWS_CS_STOP;
                        TWS_CMD_RECOVER: st_r <= TWS_CS_RECOV;
                        default: st_r <= TWS_CS_BIT;
                    endcase
                end
            end else if (tick) begin
                q_r <= q_r + 2'h1;
                case (st_r)
                    TWS_CS_START: begin
                        // Release data, raise clock, then pull data low
                        case (q_r)
                            2'h0: sda_low_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sda_low_r <= 1'b1;
                            default: begin
                                scl_r <= 1'b0;
                                st_r <= TWS_CS_IDLE;
                                ready_r <= 1'b1;
                                done_r <= 1'b1;
                            end
                        endcase
                    end
                    TWS_CS_STOP: begin
                        // Data low, clock high, then release data
                        case (q_r)
                            2'h0: sda_low_r <= 1'b1;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sda_low_r <= 1'b0;
                            default: begin
                                st_r <= TWS_CS_IDLE;
                                ready_r <= 1'b1;
                                done_r <= 1'b1;
                            end
                        endcase
                    end
                    TWS_CS_BIT: begin
                        case (q_r)
                            2'h0: begin
                                // Data changes only with clock low
                                if (bit_r != 4'h8) begin
                                    sda_low_r <= (op_r == TWS_CMD_WRITE) & ~sh_r[7];
                                end else begin
                                    sda_low_r <= (op_r == TWS_CMD_READ) & ~nack_r;
                                end
                            end
                            2'h1: scl_r <= 1'b1;
                            2'h2: begin
                                if (bit_r != 4'h8) begin
                                    sh_r <= {sh_r[6:0], sda_f_r};
                                end else begin
                                    ack_seen_r <= ~sda_f_r;
                                end
                            end
                            default: begin
                                scl_r <= 1'b0;
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == 4'h8) begin
                                    rdata_r <= sh_r;
                                    st_r <= TWS_CS_IDLE;
                                    ready_r <= 1'b1;
                                    done_r <= 1'b1;
                                end
                            end
                        endcase
                    end
                    TWS_CS_RECOV: begin
                        // Clock up to nine times until data reads high, then start
                        case (q_r)
                            2'h0: sda_low_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: begin
                                if (sda_f_r) begin
                                    st_r <= TWS_CS_START;
                                    q_r <= 2'h0;
                                end
                            end
                            default: begin
                                scl_r <= 1'b0;
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == 4'(`TWS_RECOVER_CLOCKS - 1)) begin
                                    st_r <= TWS_CS_START;
                                end
                            end
                        endcase
                    end
                    default: st_r <= TWS_CS_IDLE;
                endcase
            end
        end
    end
endmodule

// file: tws_link_asserts.sv
// Checker for the two-wire link between the bus controller and the EEPROM end.
// Assumes it sits beside the link interface and sees the device busy flag.
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_link_asserts #(
    parameter int PROG_CYCLES = `TWS_PROG_CYC
) (
    // System
    input wire logic sys_clk,
    input wire logic rst_b,
    // Link
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    // Device status
    input wire logic busy_r
);
    localparam int P_LO = PROG_CYCLES - 8;
    localparam int P_HI = PROG_CYCLES + 8;
    int busy_cnt_r;

    // Length of the current programming run
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !busy_r) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_dev_low_only: assert property (dev_sda_o == 1'b0)
        else $error("device drives data line high");
    a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device changed data while clock high");
    a_dev_drive_low: assert property ($rose(dev_sda_oe) |-> !scl)
        else $error("device began pulling with clock high");
    a_start_hold: assert property ($fell(sda) && scl |-> scl [*4])
        else $error("clock fell too soon after start");
    a_stop_release: assert property ($rose(sda) && scl |-> !dev_sda_oe [*8])
        else $error("device pulled line after stop");
    a_busy_silent: assert property (busy_r |-> !dev_sda_oe)
        else $error("device answered while programming");
    a_prog_length: assert property ($fell(busy_r) |->
        busy_cnt_r >= P_LO && busy_cnt_r <= P_HI)
        else $error("programming run of wrong length");
    a_prog_bound: assert property (busy_cnt_r <= P_HI)
        else $error("programming run too long");

    c_prog: cover property ($rose(busy_r));
    c_ack: cover property ($rose(dev_sda_oe));
    c_start: cover property ($fell(sda) && scl);
endmodule

// file: two_wire_eeprom_slave_bench.sv
// Bench joining the bus controller and the EEPROM end over one link.
// Assumes a byte array model beside the device; expected contents kept apart.
`timescale 1ns/1ps
`include "tws_defs.svh"
module two_wire_eeprom_slave_bench;
    import tws_pkg::*;
    localparam int PROG = 1000;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] straps = 3'h0;
    logic cmd_valid = 1'b0;
    logic cmd_nack = 1'b0;
    tws_cmd_t cmd_op = TWS_CMD_STOP;
    logic [7:0] cmd_data = 8'h00;
    logic [10:0] mem_addr_r;
    logic [7:0] mem_wdata_r, mem_rdata, rdata_r, d;
    logic mem_we_r, busy_r, standby_r, ready_r, done_r, ack_seen_r;
    logic [7:0] mem [2048];
    logic [7:0] exp_mem [2048];
    logic [10:0] a;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 94;

    tws_link_if link ();
    always #12.5 sys_clk = ~sys_clk;
    assign mem_rdata = mem[mem_addr_r];
    always @(posedge sys_clk) if (mem_we_r) mem[mem_addr_r] <= mem_wdata_r;

    tws_eeprom_dev #(.PROG_CYCLES(PROG)) tws_eeprom_dev_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(link.dev), .chip_select_straps(straps), .mem_addr_r(mem_addr_r),
        .mem_wdata_r(mem_wdata_r), .mem_we_r(mem_we_r), .mem_rdata(mem_rdata),
        .busy_r(busy_r), .standby_r(standby_r));
    tws_bus_ctl #(.QTR_CYC(8)) tws_bus_ctl_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .link(link.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_nack(cmd_nack), .ready_r(ready_r), .done_r(done_r), .rdata_r(rdata_r),
        .ack_seen_r(ack_seen_r));
    tws_link_asserts #(.PROG_CYCLES(PROG)) tws_link_asserts_inst (.sys_clk(sys_clk),
        .rst_b(rst_b), .scl(link.scl), .sda(link.sda), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe(link.dev_sda_oe), .busy_r(busy_r));

    task print_verdict;
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk_bit(string nm, logic e, logic g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %b got %b", nm, e, g);
        end
    endtask
    task chk_byte(string nm, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task op(tws_cmd_t o, logic [7:0] dd, logic n);
        int k;
        k = 0;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= o;
        cmd_data <= dd;
        cmd_nack <= n;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        do begin
            @(posedge sys_clk);
            #1;
            k++;
            if (k > 4000) begin
                error_cnt++;
                print_verdict();
            end
        end while (done_r !== 1'b1);
    endtask
    // Address word as the straps ask for it
    function automatic logic [7:0] dw(logic [2:0] b, logic r);
        return {1'b1, straps[2], ~straps[1], straps[0], b, r};
    endfunction
    task wr(logic [7:0] dd, logic ak);
        op(TWS_CMD_WRITE, dd, 1'b0);
        chk_bit("ack", ak, ack_seen_r);
    endtask
    task rd(logic [7:0] e, logic n);
        op(TWS_CMD_READ, 8'h00, n);
        chk_byte("rdata", e, rdata_r);
    endtask
    task sel(logic [10:0] aa, logic r);
        op(TWS_CMD_START, 8'h00, 1'b0);
        wr(dw(aa[10:8], r), 1'b1);
    endtask
    task rand_read(logic [10:0] aa);
        sel(aa, 1'b0);
        wr(aa[7:0], 1'b1);
        sel(aa, 1'b1);
    endtask
    // Write stop, busy check, one refused poll, then poll until answered
    task close_write(logic [2:0] b);
        int n;
        n = 0;
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        repeat (8) @(posedge sys_clk);
        #1 chk_bit("busy", 1'b1, busy_r);
        chk_bit("standby", 1'b0, standby_r);
        op(TWS_CMD_START, 8'h00, 1'b0);
        wr(dw(b, 1'b0), 1'b0);
        do begin
            op(TWS_CMD_STOP, 8'h00, 1'b0);
            op(TWS_CMD_START, 8'h00, 1'b0);
            op(TWS_CMD_WRITE, dw(b, 1'b0), 1'b0);
            n++;
            if (n > 20) begin
                error_cnt++;
                print_verdict();
            end
        end while (ack_seen_r !== 1'b1);
    endtask

    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
            exp_mem[i] = i[7:0] ^ 8'h5a;
        end
        @(posedge sys_clk);
        straps <= $random(seed);
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1 chk_bit("standby", 1'b1, standby_r);
        op(TWS_CMD_RECOVER, 8'h00, 1'b0);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        for (int i = 0; i < 2; i++) begin
            op(TWS_CMD_START, 8'h00, 1'b0);
            wr((i == 0) ? dw(3'h0, 1'b0) ^ 8'h20 : dw(3'h0, 1'b0) & 8'h7f, 1'b0);
            #1 chk_bit("standby", 1'b1, standby_r);
            op(TWS_CMD_STOP, 8'h00, 1'b0);
        end
        a = $random(seed);
        d = $random(seed);
        rand_read(a);
        // Finish the read with no acknowledge so the device lets go of the line
        rd(exp_mem[a], 1'b1);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        sel(a, 1'b0);
        wr(a[7:0], 1'b1);
        wr(d, 1'b1);
        exp_mem[a] = d;
        close_write(a[10:8]);
        wr(a[7:0], 1'b1);
        sel(a, 1'b1);
        rd(exp_mem[a], 1'b1);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        a = $random(seed);
        sel(a, 1'b0);
        wr(a[7:0], 1'b1);
        for (int k = 0; k < 17; k++) begin
            d = $random(seed);
            wr(d, 1'b1);
            exp_mem[{a[10:4], 4'(a[3:0] + k[3:0])}] = d;
        end
        close_write(a[10:8]);
        wr({a[7:4], 4'h0}, 1'b1);
        sel(a, 1'b1);
        for (int k = 0; k < 16; k++) rd(exp_mem[{a[10:4], k[3:0]}], k == 15);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        rand_read(11'h7ff);
        rd(exp_mem[11'h7ff], 1'b0);
        rd(exp_mem[11'h000], 1'b1);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        sel(11'h000, 1'b1);
        rd(exp_mem[11'h001], 1'b1);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        a = $random(seed);
        sel(a, 1'b0);
        wr(a[7:0], 1'b1);
        wr(~exp_mem[a], 1'b1);
        op(TWS_CMD_START, 8'h00, 1'b0);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        repeat (8) @(posedge sys_clk);
        #1 chk_bit("busy", 1'b0, busy_r);
        rand_read(a);
        rd(exp_mem[a], 1'b1);
        op(TWS_CMD_STOP, 8'h00, 1'b0);
        print_verdict();
    end
endmodule
